/* pst_pkg.sv */
// shared constants and types of the parity serial transmitter
package pst_pkg;
    // apb register byte offsets
    localparam logic [7:0]  PST_OFS_DATA      = 8'h00;
    localparam logic [7:0]  PST_OFS_CTRL      = 8'h04;
    localparam logic [7:0]  PST_OFS_STAT      = 8'h08;
    localparam logic [7:0]  PST_OFS_INT_STAT  = 8'h0C;
    localparam logic [7:0]  PST_OFS_INT_MASK  = 8'h10;
    // ctrl fields
    localparam int          PST_CTRL_GO       = 0;
    localparam logic        PST_CTRL_RST      = 1'h0;
    // stat fields
    localparam int          PST_STAT_EMPTY    = 0;
    localparam int          PST_STAT_FULL     = 1;
    localparam int          PST_STAT_DTR_N    = 2;
    localparam int          PST_STAT_OE       = 3;
    localparam int          PST_STAT_STATE_LO = 4;
    localparam int          PST_STAT_PARITY   = 8;
    // event bits, same layout in int_stat and int_mask
    localparam int          PST_EV_W          = 3;
    localparam int          PST_EV_RDDONE     = 0;
    localparam int          PST_EV_DONE       = 1;
    localparam int          PST_EV_ABORT      = 2;
    localparam logic [2:0]  PST_INT_RST       = 3'h0;
    // data path
    localparam int          PST_WORD_W        = 16;
    localparam int          PST_FIFO_AW       = 2;
    localparam int          PST_CHAR_BITS     = 7;
    localparam logic [2:0]  PST_CHAR_CNT_LAST = 3'h6;
    localparam logic [3:0]  PST_LOOP_PRELOAD  = 4'hA;
    localparam logic [15:0] PST_MASK_EVEN     = 16'h0060;
    localparam logic [15:0] PST_MASK_ODD      = 16'h00E0;
    localparam logic [15:0] PST_START_CLR     = 16'h7FFF;
    localparam logic [15:0] PST_WORD_RST      = 16'h0000;
    localparam logic [31:0] PST_RDATA_RST     = 32'h0000_0000;

    typedef enum logic [3:0] {
        PST_IDLE    = 4'h0,
        PST_FETCH   = 4'h1,
        PST_SWAP    = 4'h2,
        PST_COUNT   = 4'h3,
        PST_PARITY  = 4'h4,
        PST_WAIT_RX = 4'h5,
        PST_SHIFT   = 4'h6,
        PST_ABORT   = 4'h7
    } pst_state_t;
endpackage : pst_pkg

/* pst_fifo.sv */
// input word fifo, registered read data
`timescale 1ns/100ps
module pst_fifo #(
    parameter int W  = 16,
    parameter int AW = 2
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // fill side
    input  wire logic         push,
    input  wire logic [W-1:0] push_data,
    // drain side
    input  wire logic         pop,
    output logic      [W-1:0] pop_data,
    // levels
    output logic              empty,
    output logic              full
);
    logic [W-1:0] mem [2**AW];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0]   next_count;
    logic          do_push;
    logic          do_pop;

    // a push into a full fifo or a pop from an empty one is dropped
    always_comb begin
        do_push     = push && !full;
        do_pop      = pop && !empty;
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count;
        if (do_push && !do_pop) begin
            next_count = count + 1'b1;
        end else if (do_pop && !do_push) begin
            next_count = count - 1'b1;
        end
    end

    assign empty = (count == '0);
    assign full  = (count == (AW+1)'(2**AW));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            pop_data <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
            if (do_pop) begin
                pop_data <= mem[rd_ptr];
            end
        end
    end

    // storage carries no reset
    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end
endmodule : pst_fifo

/* pst_ones_count.sv */
// serial counter of ones in a seven bit character
`timescale 1ns/100ps
module pst_ones_count
    import pst_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // request
    input  wire logic        start,
    input  wire logic [6:0]  data,
    // result
    output logic             busy,
    output logic [2:0]       ones
);
    logic [6:0] bits;
    logic [2:0] iter;
    logic [6:0] next_bits;
    logic [2:0] next_iter;
    logic [2:0] next_ones;
    logic       next_busy;

    // one bit examined per cycle, seven cycles in all
    always_comb begin
        next_bits = bits;
        next_iter = iter;
        next_ones = ones;
        next_busy = busy;
        if (start) begin
            next_bits = data;
            next_iter = 3'h0;
            next_ones = 3'h0;
            next_busy = 1'b1;
        end else if (busy) begin
            next_bits = {bits[5:0], 1'b0};
            next_ones = ones + {2'b00, bits[6]};
            next_iter = iter + 3'h1;
            next_busy = (iter != PST_CHAR_CNT_LAST);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bits <= 7'h00;
            iter <= 3'h0;
            ones <= 3'h0;
            busy <= 1'b0;
        end else begin
            bits <= next_bits;
            iter <= next_iter;
            ones <= next_ones;
            busy <= next_busy;
        end
    end
endmodule : pst_ones_count

/* pst_transmitter.sv */
// parity serial transmitter: apb registers, framing and serial shifter
//
// Behaviour
// - host words pass through fifo to register
// - stay idle until host go is set
// - abort condition leaves character in fifo, reports abort
// - fifo read also reports read done
// - swap bytes so character sits high
// - count ones over seven single-bit steps
// - ones count parity picks even or odd mask
// - start, seven data, parity, two stops: eleven
// - frame loaded to shifter, sent on line
// - wait while receiver not ready
// - receiver ready: enable line, drive dtr low
// - loop counter preloaded ten, zero fill
// - after last bit report done, go idle
`timescale 1ns/100ps
module pst_transmitter
    import pst_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // receiver and abort handshakes
    input  wire logic        receiver_ready_input,
    input  wire logic        abort_condition_input,
    // serial side
    output logic             serial_out_port_line,
    output logic             serial_out_oe,
    output logic             dtr_n,
    // interrupt
    output logic             irq
);
    import pst_pkg::*;

    pst_state_t state;
    pst_state_t next_state;
    logic [1:0]           rx_sync;
    logic [1:0]           abort_sync;
    logic                 host_go;
    logic                 next_host_go;
    logic [PST_EV_W-1:0]  int_stat;
    logic [PST_EV_W-1:0]  int_mask;
    logic [PST_EV_W-1:0]  next_int_stat;
    logic [PST_EV_W-1:0]  next_int_mask;
    logic [PST_EV_W-1:0]  events;
    logic [31:0]          next_prdata;
    logic                 next_pready;
    logic                 next_pslverr;
    logic                 next_irq;
    logic [15:0]          work;
    logic [15:0]          next_work;
    logic [15:0]          shreg;
    logic [15:0]          next_shreg;
    logic [3:0]           loop_cnt;
    logic [3:0]           next_loop_cnt;
    logic                 next_line;
    logic                 next_oe;
    logic                 next_dtr_n;
    logic                 wr_fire;
    logic                 fifo_push;
    logic                 fifo_pop;
    logic [15:0]          fifo_rd_data;
    logic                 fifo_empty;
    logic                 fifo_full;
    logic                 cnt_start;
    logic                 cnt_busy;
    logic [2:0]           cnt_ones;
    logic                 rx_ready;
    logic                 abort_cond;

    assign rx_ready   = rx_sync[1];
    assign abort_cond = abort_sync[1];

    // pins are asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sync    <= 2'h0;
            abort_sync <= 2'h0;
        end else begin
            rx_sync    <= {rx_sync[0], receiver_ready_input};
            abort_sync <= {abort_sync[0], abort_condition_input};
        end
    end

    // ---------------- apb slave ----------------
    // one wait state: pready comes from a flop, so the access lasts two cycles
    assign wr_fire = psel && penable && pready && pwrite;
    assign fifo_push = wr_fire && (paddr == PST_OFS_DATA) && !fifo_full;

    always_comb begin
        next_pready   = psel && penable && !pready;
        next_prdata   = prdata;
        next_pslverr  = 1'b0;
        next_host_go  = host_go;
        next_int_mask = int_mask;
        if (psel && penable && !pready) begin
            next_prdata = PST_RDATA_RST;
            unique case (paddr)
                PST_OFS_DATA: begin
                    next_pslverr = pwrite && fifo_full;
                end
                PST_OFS_CTRL: begin
                    next_prdata[PST_CTRL_GO] = host_go;
                end
                PST_OFS_STAT: begin
                    next_prdata[PST_STAT_EMPTY]               = fifo_empty;
                    next_prdata[PST_STAT_FULL]                = fifo_full;
                    next_prdata[PST_STAT_DTR_N]               = dtr_n;
                    next_prdata[PST_STAT_OE]                  = serial_out_oe;
                    next_prdata[PST_STAT_STATE_LO +: 4]       = state;
                    next_prdata[PST_STAT_PARITY]              = cnt_ones[0];
                end
                PST_OFS_INT_STAT: begin
                    next_prdata[PST_EV_W-1:0] = int_stat;
                end
                PST_OFS_INT_MASK: begin
                    next_prdata[PST_EV_W-1:0] = int_mask;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
        if (wr_fire && paddr == PST_OFS_CTRL) begin
            next_host_go = pwdata[PST_CTRL_GO];
        end
        if (wr_fire && paddr == PST_OFS_INT_MASK) begin
            next_int_mask = pwdata[PST_EV_W-1:0];
        end
        // write one clears; a new event in the same cycle wins
        next_int_stat = int_stat;
        if (wr_fire && paddr == PST_OFS_INT_STAT) begin
            next_int_stat = int_stat & ~pwdata[PST_EV_W-1:0];
        end
        next_int_stat = next_int_stat | events;
        next_irq      = |(next_int_stat & next_int_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready   <= 1'b0;
            prdata   <= PST_RDATA_RST;
            pslverr  <= 1'b0;
            host_go  <= PST_CTRL_RST;
            int_stat <= PST_INT_RST;
            int_mask <= PST_INT_RST;
            irq      <= 1'b0;
        end else begin
            pready   <= next_pready;
            prdata   <= next_prdata;
            pslverr  <= next_pslverr;
            host_go  <= next_host_go;
            int_stat <= next_int_stat;
            int_mask <= next_int_mask;
            irq      <= next_irq;
        end
    end

    // ---------------- framing sequencer ----------------
    always_comb begin
        next_state    = state;
        next_work     = work;
        next_shreg    = shreg;
        next_loop_cnt = loop_cnt;
        next_line     = serial_out_port_line;
        next_oe       = serial_out_oe;
        next_dtr_n    = dtr_n;
        events        = '0;
        fifo_pop      = 1'b0;
        cnt_start     = 1'b0;
        unique case (state)
            PST_IDLE: begin
                if (host_go) begin
                    if (abort_cond) begin
                        next_state = PST_ABORT;
                    end else if (!fifo_empty) begin
                        fifo_pop                = 1'b1;
                        events[PST_EV_RDDONE]   = 1'b1;
                        next_state              = PST_FETCH;
                    end
                end
            end
            PST_FETCH: begin
                next_state = PST_SWAP;
            end
            PST_SWAP: begin
                next_work  = {fifo_rd_data[7:0], fifo_rd_data[15:8]} & PST_START_CLR;
                cnt_start  = 1'b1;
                next_state = PST_COUNT;
            end
            PST_COUNT: begin
                if (!cnt_busy) begin
                    next_state = PST_PARITY;
                end
            end
            PST_PARITY: begin
                next_work  = work | (cnt_ones[0] ? PST_MASK_ODD : PST_MASK_EVEN);
                next_state = PST_WAIT_RX;
            end
            PST_WAIT_RX: begin
                if (rx_ready) begin
                    next_oe       = 1'b1;
                    next_dtr_n    = 1'b0;
                    next_line     = work[15];
                    next_shreg    = {work[14:0], 1'b0};
                    next_loop_cnt = PST_LOOP_PRELOAD;
                    next_state    = PST_SHIFT;
                end
            end
            PST_SHIFT: begin
                if (loop_cnt == 4'h0) begin
                    events[PST_EV_DONE] = 1'b1;
                    next_line           = 1'b1;
                    next_oe             = 1'b0;
                    next_dtr_n          = 1'b1;
                    next_state          = PST_IDLE;
                end else begin
                    next_line     = shreg[15];
                    next_shreg    = {shreg[14:0], 1'b0};
                    next_loop_cnt = loop_cnt - 4'h1;
                end
            end
            PST_ABORT: begin
                events[PST_EV_ABORT] = 1'b1;
                next_state           = PST_IDLE;
            end
            default: begin
                next_state = PST_IDLE;
            end
        endcase
    end

    // line idles high so stop bits and idle look alike
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                <= PST_IDLE;
            work                 <= PST_WORD_RST;
            shreg                <= PST_WORD_RST;
            loop_cnt             <= 4'h0;
            serial_out_port_line <= 1'b1;
            serial_out_oe        <= 1'b0;
            dtr_n                <= 1'b1;
        end else begin
            state                <= next_state;
            work                 <= next_work;
            shreg                <= next_shreg;
            loop_cnt             <= next_loop_cnt;
            serial_out_port_line <= next_line;
            serial_out_oe        <= next_oe;
            dtr_n                <= next_dtr_n;
        end
    end

    pst_fifo #(
        .W  (PST_WORD_W),
        .AW (PST_FIFO_AW)
    ) pst_fifo_inst (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (fifo_push),
        .push_data (pwdata[15:0]),
        .pop       (fifo_pop),
        .pop_data  (fifo_rd_data),
        .empty     (fifo_empty),
        .full      (fifo_full)
    );

    pst_ones_count pst_ones_count_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (cnt_start),
        .data    (next_work[14:8]),
        .busy    (cnt_busy),
        .ones    (cnt_ones)
    );

    // ---------------- checks ----------------
    AST_GO_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        fifo_pop |-> host_go && state == PST_IDLE)
        else $error("fifo read without go");
    AST_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
        state == PST_IDLE && host_go && abort_cond |=> state == PST_ABORT
        ##1 int_stat[PST_EV_ABORT] && state == PST_IDLE)
        else $error("abort not reported");
    AST_RDDONE: assert property (@(posedge pclk) disable iff (!presetn)
        fifo_pop |=> int_stat[PST_EV_RDDONE] && state == PST_FETCH)
        else $error("read done missing");
    AST_SWAP: assert property (@(posedge pclk) disable iff (!presetn)
        state == PST_SWAP |=> work[14:8] == $past(fifo_rd_data[6:0]) && !work[15])
        else $error("byte swap wrong");
    AST_COUNT7: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cnt_busy) |-> cnt_busy[*7] ##1 !cnt_busy)
        else $error("ones count not seven steps");
    AST_PARITY: assert property (@(posedge pclk) disable iff (!presetn)
        state == PST_WAIT_RX |-> !(^work[14:7]) && work[6:5] == 2'b11)
        else $error("parity or stop bits wrong");
    AST_ELEVEN: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(dtr_n) |-> ##10 !dtr_n ##1 dtr_n && int_stat[PST_EV_DONE])
        else $error("frame not eleven bits");
    AST_RXWAIT: assert property (@(posedge pclk) disable iff (!presetn)
        state == PST_WAIT_RX && !rx_ready |=> state == PST_WAIT_RX && dtr_n)
        else $error("sent without receiver ready");
    AST_START: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(dtr_n) |-> serial_out_oe && !serial_out_port_line && loop_cnt == PST_LOOP_PRELOAD)
        else $error("start bit or line enable wrong");
    AST_MSB: assert property (@(posedge pclk) disable iff (!presetn)
        state == PST_SHIFT && loop_cnt != 4'h0 |=> serial_out_port_line == $past(shreg[15]))
        else $error("bit order wrong");
endmodule : pst_transmitter

/* pst_rx_model.sv */
// serial receiver model: ready handshake and frame capture
`timescale 1ns/100ps
module pst_rx_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // readiness asked by the bench
    input  wire logic        ready_en,
    // serial side
    input  wire logic        serial_out_port_line,
    input  wire logic        serial_out_oe,
    input  wire logic        dtr_n,
    output logic             receiver_ready_input,
    // captured frame
    output logic             frame_done,
    output logic [10:0]      frame,
    output logic [4:0]       nbits,
    output logic             oe_bad
);
    logic in_frame;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receiver_ready_input <= 1'b0;
            frame_done           <= 1'b0;
            frame                <= 11'h000;
            nbits                <= 5'h00;
            oe_bad               <= 1'b0;
            in_frame             <= 1'b0;
        end else begin
            receiver_ready_input <= ready_en;
            frame_done           <= 1'b0;
            if (dtr_n === 1'b0) begin
                // msb first, so shift in from the right
                frame    <= in_frame ? {frame[9:0], serial_out_port_line}
                                     : {10'h000, serial_out_port_line};
                nbits    <= in_frame ? nbits + 5'h01 : 5'h01;
                oe_bad   <= (in_frame & oe_bad) | (serial_out_oe !== 1'b1);
                in_frame <= 1'b1;
            end else if (in_frame) begin
                frame_done <= 1'b1;
                in_frame   <= 1'b0;
            end
        end
    end
endmodule : pst_rx_model

/* tb_parity_serial_transmitter.sv */
// self-checking bench of the parity serial transmitter
`timescale 1ns/100ps
module tb_parity_serial_transmitter;
    import pst_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        receiver_ready_input;
    logic        abort_condition_input = 1'b0;
    logic        serial_out_port_line;
    logic        serial_out_oe;
    logic        dtr_n;
    logic        irq;
    logic        ready_en = 1'b0;
    logic        frame_done;
    logic [10:0] frame;
    logic [4:0]  nbits;
    logic        oe_bad;
    logic [10:0] exp_q[$];
    logic [6:0]  d;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    always #4 pclk = ~pclk;

    pst_transmitter pst_transmitter_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .receiver_ready_input(receiver_ready_input),
        .abort_condition_input(abort_condition_input),
        .serial_out_port_line(serial_out_port_line),
        .serial_out_oe(serial_out_oe), .dtr_n(dtr_n), .irq(irq)
    );

    pst_rx_model pst_rx_model_inst (
        .pclk(pclk), .presetn(presetn), .ready_en(ready_en),
        .serial_out_port_line(serial_out_port_line),
        .serial_out_oe(serial_out_oe), .dtr_n(dtr_n),
        .receiver_ready_input(receiver_ready_input),
        .frame_done(frame_done), .frame(frame), .nbits(nbits), .oe_bad(oe_bad)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (!w) check(rd, exp);
        check({31'h0, err}, {31'h0, exp_err});
        @(posedge pclk);
    endtask : apb

    // expected frame: start, d1..d7, even parity, two stops
    task automatic push(input logic [6:0] c, input logic noted);
        if (noted) exp_q.push_back({1'b0, c, ^c, 2'b11});
        apb(1'b1, PST_OFS_DATA, {25'h0, c}, 32'h0, 1'b0);
    endtask : push

    task automatic drain();
        while (exp_q.size() != 0) @(posedge pclk);
        repeat (4) @(posedge pclk);
    endtask : drain

    always @(posedge pclk) begin
        if (frame_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                check({21'h0, frame}, {21'h0, exp_q.pop_front()});
                check({27'h0, nbits}, 32'h0000_000B);
                check({31'h0, oe_bad}, 32'h0);
            end
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            $display("unexpected at %0t: run hung", $time);
            report_and_stop();
        end
    end

    initial begin
        void'($urandom(87050));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, PST_OFS_STAT, 32'h0, 32'h0000_0005, 1'b0);
        apb(1'b0, PST_OFS_INT_MASK, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
        $display("test reset done");
        // fill while go is low: nothing may leave
        for (int i = 0; i < 4; i++) push(7'($urandom), 1'b1);
        apb(1'b1, PST_OFS_DATA, 32'h0000_007F, 32'h0, 1'b1);
        apb(1'b0, PST_OFS_STAT, 32'h0, 32'h0000_0006, 1'b0);
        ready_en <= 1'b1;
        apb(1'b1, PST_OFS_CTRL, 32'h1, 32'h0, 1'b0);
        drain();
        apb(1'b0, PST_OFS_INT_STAT, 32'h0, 32'h0000_0003, 1'b0);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, PST_OFS_INT_MASK, 32'h2, 32'h0, 1'b0);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, PST_OFS_INT_STAT, 32'h7, 32'h0, 1'b0);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, PST_OFS_INT_STAT, 32'h0, 32'h0, 1'b0);
        $display("test fifo and frames done");
        // receiver holds off: line must stay quiet
        ready_en <= 1'b0;
        d = 7'($urandom);
        push(d, 1'b1);
        repeat (40) @(posedge pclk);
        check({30'h0, dtr_n, serial_out_oe}, 32'h2);
        ready_en <= 1'b1;
        drain();
        $display("test receiver stall done");
        apb(1'b1, PST_OFS_INT_STAT, 32'h7, 32'h0, 1'b0);
        apb(1'b1, PST_OFS_CTRL, 32'h0, 32'h0, 1'b0);
        abort_condition_input <= 1'b1;
        push(7'h55, 1'b0);
        apb(1'b1, PST_OFS_CTRL, 32'h1, 32'h0, 1'b0);
        repeat (6) @(posedge pclk);
        apb(1'b1, PST_OFS_CTRL, 32'h0, 32'h0, 1'b0);
        repeat (4) @(posedge pclk);
        apb(1'b0, PST_OFS_INT_STAT, 32'h0, 32'h0000_0004, 1'b0);
        apb(1'b0, PST_OFS_STAT, 32'h0, {23'h0, ^d, 8'h04}, 1'b0);
        abort_condition_input <= 1'b0;
        exp_q.push_back({1'b0, 7'h55, 1'b0, 2'b11});
        repeat (4) @(posedge pclk);
        apb(1'b1, PST_OFS_CTRL, 32'h1, 32'h0, 1'b0);
        drain();
        $display("test abort done");
        // back-to-back words with go held
        for (int i = 0; i < 3; i++) begin
            d = 7'($urandom);
            push(d, 1'b1);
        end
        apb(1'b0, PST_OFS_CTRL, 32'h0, 32'h1, 1'b0);
        drain();
        check(exp_q.size(), 32'h0);
        // idle again: empty, line released, last parity shown
        apb(1'b0, PST_OFS_STAT, 32'h0, {23'h0, ^d, 8'h05}, 1'b0);
        $display("test back to back done");
        report_and_stop();
    end
endmodule : tb_parity_serial_transmitter
